// *** hw/imuff_pkg.sv ***
// Package for the inertial sensor FIFO flag, tag and readout block
package imuff_pkg;

	// Gyroscope FIFO geometry
	localparam int          GF_DEPTH         = 100;
	localparam int          GF_STREAM_FULL   = 99;
	localparam int          GF_CNT_W         = 7;
	localparam int          GF_FRAME_BYTES   = 8;
	localparam logic [2:0]  GF_LAST_BYTE     = 3'h7;

	// Gyroscope register offsets
	localparam logic [7:0]  G_RATE_FIRST     = 8'h02;
	localparam logic [7:0]  G_RATE_LAST      = 8'h07;
	localparam logic [7:0]  G_INT_STATUS     = 8'h0A;
	localparam logic [7:0]  G_FILL_STATUS    = 8'h0E;
	localparam logic [7:0]  G_TAG_CFG        = 8'h34;
	localparam logic [7:0]  G_WM_LEVEL       = 8'h3D;
	localparam logic [7:0]  G_MODE_CFG       = 8'h3E;
	localparam logic [7:0]  G_READ_PORT      = 8'h3F;

	// Gyroscope field positions and codes
	localparam int          G_STAT_WM_BIT    = 4;
	localparam int          G_STAT_FULL_BIT  = 5;
	localparam int          G_OVR_BIT        = 7;
	localparam int          G_TAG_EN_BIT     = 5;
	localparam int          G_TAG_PIN_BIT    = 4;
	localparam int          G_MODE_LSB       = 6;
	localparam logic [1:0]  G_MODE_FIFO      = 2'h1;
	localparam logic [1:0]  G_MODE_STREAM    = 2'h2;
	localparam logic [7:0]  G_TAG_CFG_RST    = 8'h00;
	localparam logic [7:0]  G_WM_RST         = 8'h00;
	localparam logic [7:0]  G_MODE_RST       = 8'h00;

	// Accelerometer register offsets and codes
	localparam logic [7:0]  A_FIFO_STATUS    = 8'h1E;
	localparam logic [7:0]  A_FIFO_DATA      = 8'h26;
	localparam logic [7:0]  A_WM_LO          = 8'h46;
	localparam logic [7:0]  A_WM_HI          = 8'h47;
	localparam logic [7:0]  A_COMMAND        = 8'h7E;
	localparam logic [7:0]  A_CMD_FIFO_RESET = 8'hB0;
	localparam logic [12:0] A_WM_RST         = 13'h0200;
	localparam int          A_FULL_BIT       = 0;
	localparam int          A_WM_BIT         = 1;

	// Accelerometer FIFO geometry in bytes
	localparam int          A_FILL_W         = 11;
	localparam int          A_FIFO_BYTES     = 1024;
	localparam int          A_FRAME_BYTES    = 7;
	localparam logic [10:0] A_FULL_THR       = 11'(A_FIFO_BYTES - 2 * A_FRAME_BYTES);

	// Host register request, one per clock
	typedef struct packed {
		logic       gyro_map;
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic       burst;
		logic [7:0] wdata;
	} imuff_reg_req_t;

	// Angular rate sample as shown in the rate registers
	typedef struct packed {
		logic [15:0] z;
		logic [15:0] y;
		logic [15:0] x;
	} imuff_rate_t;

	// Stored gyroscope frame, x in the low word
	typedef struct packed {
		logic [15:0] intd;
		logic [15:0] z;
		logic [15:0] y;
		logic [15:0] x;
	} imuff_frame_t;

endpackage : imuff_pkg

// *** hw/imuff_fifo.sv ***
// Parameterised synchronous FIFO with valid/ready on both sides
module imuff_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         resetn,
	input  wire logic                         flush,
	// Fill side
	input  wire logic                         in_valid,
	output logic                              in_ready,
	input  wire logic [WIDTH-1:0]             in_data,
	// Drain side
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic [WIDTH-1:0]                  out_data,
	output logic [$clog2(DEPTH+1)-1:0]        count
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wptr_q;
	logic [PW-1:0]    rptr_q;
	logic [CW-1:0]    count_q;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction : next_ptr

	// A full FIFO still takes a word when one leaves in the same cycle
	assign in_ready  = (count_q != CW'(DEPTH)) || out_ready;
	assign out_valid = (count_q != '0);
	assign out_data  = mem[rptr_q];
	assign count     = count_q;
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk) begin
		if (!resetn || flush) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wptr_q <= next_ptr(wptr_q);
			end
			if (pop) begin
				rptr_q <= next_ptr(rptr_q);
			end
			count_q <= count_q + CW'(push) - CW'(pop);
		end
	end

endmodule : imuff_fifo

// *** hw/imuff_top.sv ***
// FIFO flags, event tagging and frame readout for the inertial sensor

// Functional notes
// - Accel full interrupt when fill exceeds threshold two frames short of full.
// - Accel watermark interrupt when fill is at or above programmed watermark.
// - Both accel FIFO interrupts are held off during a data port read.
// - A latched interrupt clears after a status read and fill below its threshold.
// - Writing 0xB0 to accel command register 0x7E resets the accel FIFO.
// - Gyro FIFO holds 100 frames of three rate words plus an interrupt word.
// - Gyro FIFO runs once a FIFO mode is chosen in register 0x3E.
// - Gyro FIFO takes one frame per output data rate tick, no decimation.
// - Only one gyro interrupt pin may become the event input; it stops driving.
// - Register gyro_event_tag_config bit 5 enables tagging, bit 4 picks the event pin.
// - In tag mode the z-axis LSB of each frame carries the tag.
// - Tag is 1 while the input is high, plus one frame after it falls.
// - FIFO stores the values shown in rate registers 0x02-0x07, except the z LSB in tag mode.
// - Data port 0x3F delivers whole frames in order during a burst.
// - A burst ending mid-frame drops the rest and realigns on the next frame.
// - Register 0x0E bits 6:0 show the number of stored frames.
// - A frame arriving while full sets the overrun flag, 0x0E bit 7.
// - FIFO reset zeroes the count; config writes clear the overrun flag.
// - Draining to zero leaves overrun set; only config writes clear it.
// - Gyro full interrupt at 100 frames in FIFO mode, 99 in stream; status at 0x0A.
// - Gyro watermark interrupt when count reaches the level in gyro_fifo_watermark_level; 0x0A bit 4.
// - Any write to gyro_fifo_watermark_level empties the gyro FIFO.
// - Registers are 8-bit; separate accel and gyro maps, selected by the host.
// - In stream mode a full FIFO overwrites its oldest frame.
module imuff_top import imuff_pkg::*; #(
	parameter int GF_FRAMES = GF_DEPTH
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// Host register access
	input  wire imuff_reg_req_t       reg_req,
	output logic [7:0]                reg_rdata,
	// Sensor data on the core clock
	input  wire imuff_rate_t          gyro_rate,
	input  wire logic [A_FILL_W-1:0]  accel_fill_bytes,
	// Output data rate clock from the sensor core
	input  wire logic                 odr_clk_pin,
	// Gyroscope interrupt pins
	input  wire logic                 gyro_irq_pin_a_i,
	output logic                      gyro_irq_pin_a_o,
	output logic                      gyro_irq_pin_a_oe,
	input  wire logic                 gyro_irq_pin_b_i,
	output logic                      gyro_irq_pin_b_o,
	output logic                      gyro_irq_pin_b_oe,
	// Accelerometer FIFO control and interrupts
	output logic                      accel_fifo_reset,
	output logic                      accel_fifo_full_irq,
	output logic                      accel_fifo_wm_irq
);
	localparam int CW = $clog2(GF_FRAMES + 1);

	// Register access decode
	logic              g_wr;
	logic              g_rd;
	logic              a_wr;
	logic              a_rd;
	logic              cfg_wr;
	logic              flush;

	// Synchronisers and tick
	logic [2:0]        odr_sync_q;
	logic [1:0]        pin_a_sync_q;
	logic [1:0]        pin_b_sync_q;
	logic              odr_tick;

	// Gyro configuration and state
	logic [7:0]        tag_cfg_q;
	logic [7:0]        gwm_q;
	logic [7:0]        gmode_q;
	logic [1:0]        gmode;
	logic              fifo_on;
	logic              stream;
	logic              tag_en;
	logic              tag_pin_b;
	logic              event_in;
	logic              ev_hold_q;
	logic              tag_bit;
	logic              overrun_q;
	logic              g_full;
	logic              g_wm;
	logic              g_irq_q;
	logic [2:0]        byte_idx_q;
	logic              burst_q;
	logic              port_rd;
	logic              rd_pop;
	logic              realign;
	logic              discard;

	// Gyro FIFO connections
	imuff_frame_t      frame_in;
	imuff_frame_t      frame_out;
	logic              push_valid;
	logic              push_ready;
	logic              head_valid;
	logic              head_ready;
	logic [CW-1:0]     g_count;
	logic              g_is_full;

	// Accelerometer state
	logic [12:0]       awm_q;
	logic [1:0]        a_cond;
	logic [1:0]        a_lat_q;
	logic [1:0]        a_seen_q;
	logic [1:0]        a_lat_d;
	logic              a_busy;
	logic              a_stat_rd;
	logic              a_cmd_q;

	// Read data path
	logic [7:0]        rdata_d;
	logic [7:0]        rdata_q;

	// Register hit within one map
	function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
		hit = strobe && (addr == ofs);
	endfunction : hit

	// Byte n of a frame, x low byte first
	function automatic logic [7:0] frame_byte(input imuff_frame_t f, input logic [2:0] n);
		frame_byte = f[n*8 +: 8];
	endfunction : frame_byte

	// Each access goes to exactly one map
	assign g_wr = reg_req.wr && reg_req.gyro_map;
	assign g_rd = reg_req.rd && reg_req.gyro_map;
	assign a_wr = reg_req.wr && !reg_req.gyro_map;
	assign a_rd = reg_req.rd && !reg_req.gyro_map;

	// Config writes clear overrun; both config registers also empty the FIFO
	assign cfg_wr = hit(g_wr, reg_req.addr, G_WM_LEVEL) || hit(g_wr, reg_req.addr, G_MODE_CFG);
	assign flush  = cfg_wr;

	// Two flops before any logic; third flop only for edge finding
	always_ff @(posedge clk) begin
		if (!resetn) begin
			odr_sync_q   <= '0;
			pin_a_sync_q <= '0;
			pin_b_sync_q <= '0;
		end else begin
			odr_sync_q   <= {odr_sync_q[1:0], odr_clk_pin};
			pin_a_sync_q <= {pin_a_sync_q[0], gyro_irq_pin_a_i};
			pin_b_sync_q <= {pin_b_sync_q[0], gyro_irq_pin_b_i};
		end
	end

	// One frame per rising rate clock edge, never decimated
	assign odr_tick = odr_sync_q[1] && !odr_sync_q[2];

	// Gyro configuration registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tag_cfg_q <= G_TAG_CFG_RST;
			gwm_q     <= G_WM_RST;
			gmode_q   <= G_MODE_RST;
		end else begin
			if (hit(g_wr, reg_req.addr, G_TAG_CFG)) begin
				tag_cfg_q <= reg_req.wdata;
			end
			if (hit(g_wr, reg_req.addr, G_WM_LEVEL)) begin
				gwm_q <= reg_req.wdata;
			end
			if (hit(g_wr, reg_req.addr, G_MODE_CFG)) begin
				gmode_q <= reg_req.wdata;
			end
		end
	end

	assign gmode     = gmode_q[G_MODE_LSB +: 2];
	assign fifo_on   = (gmode == G_MODE_FIFO) || (gmode == G_MODE_STREAM);
	assign stream    = (gmode == G_MODE_STREAM);
	assign tag_en    = tag_cfg_q[G_TAG_EN_BIT];
	assign tag_pin_b = tag_cfg_q[G_TAG_PIN_BIT];

	// Only the chosen pin is read as the event, so one pin at most is an input
	assign event_in = tag_en && (tag_pin_b ? pin_b_sync_q[1] : pin_a_sync_q[1]);

	// Hold remembers a high level seen since the last frame, so one late frame is tagged
	always_ff @(posedge clk) begin
		if (!resetn || !tag_en) begin
			ev_hold_q <= 1'b0;
		end else if (push_valid) begin
			ev_hold_q <= event_in;
		end else if (event_in) begin
			ev_hold_q <= 1'b1;
		end
	end

	assign tag_bit = event_in || ev_hold_q;

	// Frame built from the values the rate registers show, except z LSB, which carries the tag in tag mode
	always_comb begin
		frame_in.x    = gyro_rate.x;
		frame_in.y    = gyro_rate.y;
		frame_in.z    = tag_en ? {gyro_rate.z[15:1], tag_bit} : gyro_rate.z;
		frame_in.intd = {13'h0000, event_in, g_wm, g_full};
	end

	assign push_valid = odr_tick && fifo_on;
	assign g_is_full  = (g_count == CW'(GF_FRAMES));

	// Stream mode drops the head in the cycle a new frame arrives on a full buffer
	assign discard = push_valid && stream && g_is_full;

	// Frame store; in FIFO mode a full buffer refuses the new frame unless a read or realign pop frees a slot in that cycle
	imuff_fifo #(
		.WIDTH ($bits(imuff_frame_t)),
		.DEPTH (GF_FRAMES)
	) u_frames (
		.clk       (clk),
		.resetn    (resetn),
		.flush     (flush),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (frame_in),
		.out_valid (head_valid),
		.out_ready (head_ready),
		.out_data  (frame_out),
		.count     (g_count)
	);

	// Overrun: set wins over a clearing config write; reads never clear it
	always_ff @(posedge clk) begin
		if (!resetn) begin
			overrun_q <= 1'b0;
		end else if (push_valid && g_is_full) begin
			overrun_q <= 1'b1;
		end else if (cfg_wr) begin
			overrun_q <= 1'b0;
		end
	end

	// Full and watermark levels from the frame count
	assign g_full = stream ? (g_count >= CW'(GF_STREAM_FULL)) : g_is_full;
	assign g_wm   = (gwm_q[GF_CNT_W-1:0] != '0) && (g_count >= CW'(gwm_q[GF_CNT_W-1:0]));

	// Data port reads walk the head frame a byte at a time
	assign port_rd = hit(g_rd, reg_req.addr, G_READ_PORT);
	assign rd_pop  = port_rd && head_valid && (byte_idx_q == GF_LAST_BYTE);

	// End of a burst part way into a frame throws the rest of that frame away
	assign realign = burst_q && !reg_req.burst && head_valid && (byte_idx_q != '0);

	// One pop per cycle; a read pop that meets a discard takes the same head, so only one frame leaves
	assign head_ready = rd_pop || realign || discard;

	// Byte position and burst edge tracking
	always_ff @(posedge clk) begin
		if (!resetn || flush) begin
			byte_idx_q <= '0;
			burst_q    <= 1'b0;
		end else begin
			burst_q <= reg_req.burst && reg_req.gyro_map;
			if (realign || discard) begin
				byte_idx_q <= '0;
			end else if (port_rd && head_valid) begin
				byte_idx_q <= byte_idx_q + 3'h1;
			end
		end
	end

	// Gyro interrupt pins; the event pin is released and only read
	always_ff @(posedge clk) begin
		if (!resetn) begin
			g_irq_q <= 1'b0;
		end else begin
			g_irq_q <= g_full || g_wm;
		end
	end

	assign gyro_irq_pin_a_o  = g_irq_q;
	assign gyro_irq_pin_b_o  = g_irq_q;
	assign gyro_irq_pin_a_oe = !(tag_en && !tag_pin_b);
	assign gyro_irq_pin_b_oe = !(tag_en && tag_pin_b);

	// Accelerometer watermark level, low and high bytes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			awm_q <= A_WM_RST;
		end else begin
			if (hit(a_wr, reg_req.addr, A_WM_LO)) begin
				awm_q[7:0] <= reg_req.wdata;
			end
			if (hit(a_wr, reg_req.addr, A_WM_HI)) begin
				awm_q[12:8] <= reg_req.wdata[4:0];
			end
		end
	end

	// Accel FIFO conditions and data port activity
	assign a_cond[A_FULL_BIT] = (accel_fill_bytes > A_FULL_THR);
	assign a_cond[A_WM_BIT]   = ({2'b00, accel_fill_bytes} >= awm_q);
	assign a_busy    = reg_req.burst && !reg_req.gyro_map && (reg_req.addr == A_FIFO_DATA);
	assign a_stat_rd = hit(a_rd, reg_req.addr, A_FIFO_STATUS);

	// Latch sets while the condition holds; clears after a status read once it drops
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			a_lat_d[i] = (a_cond[i] && !a_busy)
			             || (a_lat_q[i] && !((a_stat_rd || a_seen_q[i]) && !a_cond[i]));
		end
	end

	// Status read is remembered until the level falls under the threshold
	always_ff @(posedge clk) begin
		if (!resetn) begin
			a_lat_q  <= '0;
			a_seen_q <= '0;
		end else begin
			a_lat_q  <= a_lat_d;
			a_seen_q <= a_lat_d & (a_seen_q | {2{a_stat_rd}});
		end
	end

	assign accel_fifo_full_irq = a_lat_q[A_FULL_BIT];
	assign accel_fifo_wm_irq   = a_lat_q[A_WM_BIT];

	// FIFO reset command, a one-cycle pulse to the accel FIFO
	always_ff @(posedge clk) begin
		if (!resetn) begin
			a_cmd_q <= 1'b0;
		end else begin
			a_cmd_q <= hit(a_wr, reg_req.addr, A_COMMAND) && (reg_req.wdata == A_CMD_FIFO_RESET);
		end
	end

	assign accel_fifo_reset = a_cmd_q;

	// Read mux; unmapped and write-only offsets read as zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_req.gyro_map) begin
			unique case (reg_req.addr)
				G_INT_STATUS: begin
					rdata_d[G_STAT_WM_BIT]   = g_wm;
					rdata_d[G_STAT_FULL_BIT] = g_full;
				end
				G_FILL_STATUS: begin
					rdata_d = {overrun_q, 7'(g_count)};
				end
				G_TAG_CFG:   rdata_d = tag_cfg_q;
				G_WM_LEVEL:  rdata_d = gwm_q;
				G_MODE_CFG:  rdata_d = gmode_q;
				G_READ_PORT: rdata_d = head_valid ? frame_byte(frame_out, byte_idx_q) : 8'h00;
				default: begin
					if (reg_req.addr >= G_RATE_FIRST && reg_req.addr <= G_RATE_LAST) begin
						rdata_d = gyro_rate[(reg_req.addr - G_RATE_FIRST) * 8 +: 8];
					end
				end
			endcase
		end else begin
			unique case (reg_req.addr)
				A_FIFO_STATUS: rdata_d = {6'h00, a_lat_q[A_WM_BIT], a_lat_q[A_FULL_BIT]};
				A_WM_LO:       rdata_d = awm_q[7:0];
				A_WM_HI:       rdata_d = {3'h0, awm_q[12:8]};
				default:       rdata_d = 8'h00;
			endcase
		end
	end

	// Registered read data, valid the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (reg_req.rd) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : imuff_top

// *** verif/imuff_top_checker.sv ***
// Port-level concurrent checks for the FIFO flag, tag and readout block
module imuff_top_checker import imuff_pkg::*; #(
	parameter int GF_FRAMES = GF_DEPTH
) (
	// Clock and reset
	input wire logic                clk,
	input wire logic                resetn,
	// Host and sensor side
	input wire imuff_reg_req_t      reg_req,
	input wire logic [7:0]          reg_rdata,
	input wire logic [A_FILL_W-1:0] accel_fill_bytes,
	input wire logic                odr_clk_pin,
	// Pins and accel outputs
	input wire logic                gyro_irq_pin_a_oe,
	input wire logic                gyro_irq_pin_b_oe,
	input wire logic                accel_fifo_reset,
	input wire logic                accel_fifo_full_irq,
	input wire logic                accel_fifo_wm_irq
);
	logic [12:0] wm_q;
	logic [1:0]  tag_q;
	logic        a_wr, g_wr, g_rd, hold, full_c, wm_c, cmd_hit;

	// Decoded requests and the accel conditions
	assign a_wr    = reg_req.wr && !reg_req.gyro_map;
	assign g_wr    = reg_req.wr && reg_req.gyro_map;
	assign g_rd    = reg_req.rd && reg_req.gyro_map;
	assign hold    = reg_req.burst && !reg_req.gyro_map && reg_req.addr == A_FIFO_DATA;
	assign full_c  = accel_fill_bytes > A_FULL_THR;
	assign wm_c    = {2'h0, accel_fill_bytes} >= wm_q;
	assign cmd_hit = a_wr && reg_req.addr == A_COMMAND && reg_req.wdata == A_CMD_FIFO_RESET;

	// Shadow of the accel watermark, so the checker needs no internal probe
	always_ff @(posedge clk) begin
		if (!resetn) wm_q <= A_WM_RST;
		else if (a_wr && reg_req.addr == A_WM_LO) wm_q[7:0] <= reg_req.wdata;
		else if (a_wr && reg_req.addr == A_WM_HI) wm_q[12:8] <= reg_req.wdata[4:0];
	end

	// Shadow of tag enable and pin select
	always_ff @(posedge clk) begin
		if (!resetn) tag_q <= 2'h0;
		else if (g_wr && reg_req.addr == G_TAG_CFG) tag_q <= reg_req.wdata[5:4];
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Config write then count read, rate clock quiet so no tick can land
	sequence quiet_s; (!odr_clk_pin) [*4]; endsequence
	sequence cfg_wr_s; g_wr && (reg_req.addr == G_MODE_CFG || reg_req.addr == G_WM_LEVEL) && !odr_clk_pin; endsequence
	sequence cnt_rd_s; g_rd && reg_req.addr == G_FILL_STATUS && !odr_clk_pin; endsequence

	reset_pulse_a: assert property (cmd_hit |=> accel_fifo_reset) else $error("reset pulse missing");
	reset_cause_a: assert property (accel_fifo_reset |-> $past(cmd_hit)) else $error("stray reset pulse");
	full_set_a: assert property (full_c && !hold |=> accel_fifo_full_irq) else $error("full irq not set");
	wm_set_a: assert property (wm_c && !hold |=> accel_fifo_wm_irq) else $error("wm irq not set");
	full_hold_a: assert property ($rose(accel_fifo_full_irq) |-> $past(full_c && !hold))
		else $error("full irq in read");
	full_clear_a: assert property ($fell(accel_fifo_full_irq) |-> $past(!full_c))
		else $error("full irq cleared early");
	wm_clear_a: assert property ($fell(accel_fifo_wm_irq) |-> $past(!wm_c)) else $error("wm irq cleared early");
	pin_role_a: assert property (!(g_wr && reg_req.addr == G_TAG_CFG) [*2] |->
		gyro_irq_pin_a_oe == !(tag_q == 2'h2) && gyro_irq_pin_b_oe == !(tag_q == 2'h3)) else $error("pin role");
	unmapped_zero_a: assert property (g_rd && reg_req.addr > G_READ_PORT |=> reg_rdata == 8'h00) else $error("unmapped");
	count_bound_a: assert property (g_rd && reg_req.addr == G_FILL_STATUS |=> reg_rdata[6:0] <= GF_FRAMES)
		else $error("count above depth");
	cfg_flush_a: assert property (quiet_s ##1 cfg_wr_s ##[1:2] cnt_rd_s |=> reg_rdata == 8'h00)
		else $error("config write kept data");
endmodule : imuff_top_checker

bind imuff_top imuff_top_checker #(.GF_FRAMES(GF_FRAMES)) imuff_top_checker_i (.clk(clk), .resetn(resetn),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .accel_fill_bytes(accel_fill_bytes), .odr_clk_pin(odr_clk_pin),
	.gyro_irq_pin_a_oe(gyro_irq_pin_a_oe), .gyro_irq_pin_b_oe(gyro_irq_pin_b_oe), .accel_fifo_reset(accel_fifo_reset),
	.accel_fifo_full_irq(accel_fifo_full_irq), .accel_fifo_wm_irq(accel_fifo_wm_irq));

// *** verif/imuff_odr_model.sv ***
// Sensor core model: rate clock and live angular rate sample
module imuff_odr_model import imuff_pkg::*; (
	// Core clock for alignment
	input wire logic clk,
	// Toward the block
	output logic     odr_clk_pin,
	output imuff_rate_t gyro_rate
);
	timeunit 1ns;
	timeprecision 1ps;
	// Rate clock stands low between samples
	initial begin
		odr_clk_pin = 1'b0;
		gyro_rate = '0;
	end
	// One tick of 320 ns, off phase from the core clock; sample stands till next tick
	task automatic tick(input imuff_rate_t r);
		@(posedge clk);
		gyro_rate <= r;
		#7 odr_clk_pin = 1'b1;
		#160 odr_clk_pin = 1'b0;
		#153;
	endtask : tick
endmodule : imuff_odr_model

// *** verif/imuff_top_bench.sv ***
// Self-checking bench for the FIFO flag, tag and readout block
module imuff_top_bench import imuff_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
		$display("CHECK FAILED %0t %s", $time, m); end end
	// Design-facing signals
	logic                clk, resetn, odr, ev_a, a_o, a_oe, b_o, b_oe, a_in, b_in, rst_p, a_full, a_wm;
	imuff_reg_req_t      req;
	imuff_rate_t         rate;
	logic [7:0]          rdata, q;
	logic [A_FILL_W-1:0] fill;
	logic [7:0]          ra[6] = '{G_TAG_CFG, G_WM_LEVEL, G_MODE_CFG, G_FILL_STATUS, G_READ_PORT, 8'h55};
	// Reference model: expected frames and tag don't-care marks
	logic [47:0]         exp_q[$];
	bit                  dc_q[$];
	int                  n_errors = 0, samples_checked = 0, md = 0;
	bit                  tag_on = 0, prev_ev = 0;

	// Wire levels; released pin a carries ev_a, released pin b shows the inverse of b_o
	assign a_in = a_oe ? a_o : ev_a;
	assign b_in = b_oe ? b_o : ~b_o;

	imuff_top imuff_top_i (.clk(clk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata), .gyro_rate(rate),
		.accel_fill_bytes(fill), .odr_clk_pin(odr), .gyro_irq_pin_a_i(a_in), .gyro_irq_pin_a_o(a_o),
		.gyro_irq_pin_a_oe(a_oe), .gyro_irq_pin_b_i(b_in), .gyro_irq_pin_b_o(b_o), .gyro_irq_pin_b_oe(b_oe),
		.accel_fifo_reset(rst_p), .accel_fifo_full_irq(a_full), .accel_fifo_wm_irq(a_wm));
	imuff_odr_model imuff_odr_model_i (.clk(clk), .odr_clk_pin(odr), .gyro_rate(rate));

	// 25 MHz core clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// One register access; burst stays as given so reads chain inside a burst
	task automatic acc(input bit g, input logic [7:0] a, input bit w, input logic [7:0] d, input bit b);
		@(posedge clk);
		req <= '{g, a, w, !w, b, d};
		@(posedge clk);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		#1 q = rdata;
	endtask : acc

	task automatic rd(input logic [7:0] a);
		acc(1, a, 0, 8'h00, 0);
	endtask : rd

	// Gyro register write; config writes also empty the model
	task automatic cfg(input logic [7:0] a, input logic [7:0] d);
		acc(1, a, 1, d, 0);
		if (a != G_TAG_CFG) begin
			exp_q.delete();
			dc_q.delete();
		end
	endtask : cfg

	// Samples with the event pin level; model keeps the mode's full behaviour
	task automatic ticks(input int n, input bit ev);
		imuff_rate_t r;
		repeat (n) begin
			r = 48'({$urandom, $urandom});
			@(posedge clk) ev_a <= ev;
			if (md == 2 && exp_q.size() == GF_DEPTH) begin
				void'(exp_q.pop_front());
				void'(dc_q.pop_front());
			end
			if (md != 0 && exp_q.size() < GF_DEPTH) begin
				exp_q.push_back(tag_on ? {r[47:33], ev, r[31:0]} : r);
				dc_q.push_back(tag_on && prev_ev && !ev);
			end
			prev_ev = ev;
			imuff_odr_model_i.tick(r);
		end
	endtask : ticks

	// Burst of whole frames, then an optional partial frame, then burst ends
	task automatic frames(input int n, input int part);
		logic [63:0] f;
		logic [47:0] e;
		repeat (n) begin
			for (int k = 0; k < 8; k++) begin
				acc(1, G_READ_PORT, 0, 8'h00, 1);
				f[8*k +: 8] = q;
			end
			e = exp_q.pop_front();
			if (dc_q.pop_front()) f[32] = e[32];
			`CHK(f[47:0], e, "frame data")
		end
		repeat (part) acc(1, G_READ_PORT, 0, 8'h00, 1);
		@(posedge clk) req.burst <= 1'b0;
		if (part > 0) begin
			void'(exp_q.pop_front());
			void'(dc_q.pop_front());
		end
	endtask : frames

	task automatic setf(input logic [A_FILL_W-1:0] v);
		@(posedge clk) fill <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask : setf

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	// Main sequence
	initial begin
		void'($urandom(95441));
		{resetn, ev_a, fill, req} = '0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i]);
			`CHK(q, 8'h00, "reset or empty read")
		end
		$display("reset values done");
		cfg(G_WM_LEVEL, 8'h06);
		cfg(G_TAG_CFG, 8'h20);
		tag_on = 1;
		cfg(G_MODE_CFG, 8'h40);
		md = 1;
		`CHK({a_oe, b_oe}, 2'b01, "event pin role")
		ticks(2, 0);
		ticks(2, 1);
		ticks(2, 0);
		rd(G_RATE_LAST);
		`CHK(q, rate[47:40], "rate register")
		rd(G_FILL_STATUS);
		`CHK(q, 8'h06, "frame count")
		rd(G_INT_STATUS);
		`CHK(q[G_STAT_WM_BIT], 1'b1, "watermark status")
		frames(2, 3);
		rd(G_FILL_STATUS);
		`CHK(q, 8'h03, "count after partial frame")
		frames(3, 0);
		cfg(G_TAG_CFG, 8'h30);
		`CHK({a_oe, b_oe}, 2'b10, "pin b as event")
		cfg(G_TAG_CFG, 8'h00);
		tag_on = 0;
		$display("tag and readout done");
		cfg(G_MODE_CFG, 8'h40);
		ticks(99, 0);
		rd(G_INT_STATUS);
		`CHK(q[G_STAT_FULL_BIT], 1'b0, "not full at 99")
		ticks(2, 0);
		rd(G_FILL_STATUS);
		`CHK(q, 8'hE4, "full count with overrun")
		rd(G_INT_STATUS);
		`CHK(q[G_STAT_FULL_BIT], 1'b1, "full status")
		frames(100, 0);
		rd(G_FILL_STATUS);
		`CHK(q, 8'h80, "overrun kept when drained")
		cfg(G_MODE_CFG, 8'h80);
		md = 2;
		rd(G_FILL_STATUS);
		`CHK(q, 8'h00, "config write clears")
		ticks(99, 0);
		rd(G_INT_STATUS);
		`CHK(q[G_STAT_FULL_BIT], 1'b1, "stream full at 99")
		`CHK({a_o, b_o}, 2'b11, "irq pins driven")
		ticks(3, 0);
		frames(1, 0);
		cfg(G_WM_LEVEL, 8'h00);
		rd(G_FILL_STATUS);
		`CHK(q, 8'h00, "watermark write empties")
		cfg(G_MODE_CFG, 8'h00);
		md = 0;
		ticks(1, 0);
		rd(G_FILL_STATUS);
		`CHK(q, 8'h00, "emptied and mode off")
		`CHK({a_o, b_o}, 2'b00, "irq pins idle")
		$display("gyro full and stream done");
		acc(0, A_WM_LO, 1, 8'h10, 0);
		acc(0, A_WM_HI, 1, 8'h00, 0);
		setf(11'd20);
		`CHK({a_full, a_wm}, 2'b01, "accel watermark only")
		setf(A_FULL_THR + 11'(1 + $urandom % 13));
		`CHK(a_full, 1'b1, "accel full")
		setf(11'd0);
		`CHK(a_full, 1'b1, "latched before status read")
		acc(0, A_FIFO_STATUS, 0, 8'h00, 0);
		setf(11'd0);
		`CHK({a_full, a_wm}, 2'b00, "cleared after status read")
		@(posedge clk) req <= '{1'b0, A_FIFO_DATA, 1'b0, 1'b0, 1'b1, 8'h00};
		setf(11'd1020);
		`CHK(a_full, 1'b0, "held off during data read")
		@(posedge clk) req.burst <= 1'b0;
		setf(11'd1020);
		`CHK(a_full, 1'b1, "set after data read")
		acc(0, A_COMMAND, 1, A_CMD_FIFO_RESET, 0);
		`CHK(rst_p, 1'b1, "fifo reset pulse")
		acc(0, A_COMMAND, 1, 8'hB6, 0);
		`CHK(rst_p, 1'b0, "other code ignored")
		$display("accel flags done");
		finish_test();
	end

	// Watchdog well beyond the expected run
	initial begin
		#2000000;
		n_errors++;
		$display("CHECK FAILED %0t watchdog", $time);
		finish_test();
	end
endmodule : imuff_top_bench
